// File: src/pre_pkg.sv
// Package for the processor reset entry block: types and constants
package pre_pkg;

  // Synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 3;

  // Reset values
  localparam logic       TEST_MODE_RST = 1'b0;
  // Pulled-up pins idle high; the reset pin counts as held until seen
  localparam logic       PIN_IDLE_RST  = 1'b1;
  localparam logic       RST_PIN_RST   = 1'b0;

  // Pin group with weak pull-ups during reset
  typedef struct packed {
    logic       lock_n;          // Bus lock pin
    logic       addr19_test_strap; // Top address pin
    logic [2:0] upper_addr_bits; // Next three address pins
  } pre_pins_t;

  // Reset entry state
  typedef enum logic [1:0] {
    PRE_ST_RESET = 2'b00,
    PRE_ST_RUN   = 2'b01
  } pre_state_t;

endpackage

// File: src/pre_sync.sv
// Three-stage synchroniser with agreement-based change detection
`timescale 1ns/1ps
module pre_sync #(
  parameter logic RST_VAL = pre_pkg::PIN_IDLE_RST  // Level assumed before the pin is seen
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  import pre_pkg::*;

  logic [SYNC_STAGES-1:0] sh_reg;   // Shift chain
  logic [SYNC_STAGES-1:0] sh_next;
  logic                   out_reg;  // Accepted level
  logic                   out_next;

  // Next values; stage 0 is only read by stage 1
  always_comb begin
    sh_next  = {sh_reg[SYNC_STAGES-2:0], async_in};
    out_next = out_reg;
    if (sh_reg[SYNC_STAGES-2] == sh_reg[SYNC_STAGES-1]) begin
      out_next = sh_reg[SYNC_STAGES-1];
    end
  end

  // Registers; reset level chosen per pin by the instance
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sh_reg  <= {SYNC_STAGES{RST_VAL}};
      out_reg <= RST_VAL;
    end else begin
      sh_reg  <= sh_next;
      out_reg <= out_next;
    end
  end

  assign sync_out = out_reg;
endmodule

// File: src/pre_reset_entry.sv
// Reset entry logic: reset hold, bus abort, pin float and test strap
`timescale 1ns/1ps
// How it works
// R1 - Stay in reset while reset input low
// R2 - Source holds reset until clocks stable
// R3 - Source asserts reset during power-up
// R4 - Reset aborts running bus cycle immediately
// R5 - Reset turns lock/address pins to pulled-up inputs
// R6 - Only top address low selects test mode
// R7 - Latch test mode from strap at release
module pre_reset_entry (
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          ext_reset_n,
  input  pre_pkg::pre_pins_t pins_in,
  input  pre_pkg::pre_pins_t pins_drv,
  input  pre_pkg::pre_pins_t pins_drv_oe,
  input  wire logic          bus_cycle_active,
  output pre_pkg::pre_pins_t pins_out,
  output pre_pkg::pre_pins_t pins_oe,
  output pre_pkg::pre_pins_t pins_pullup,
  output logic               core_reset,
  output logic               bus_abort,
  output logic               test_mode
);
  import pre_pkg::*;

  logic       ext_rst_sync;  // Synchronised reset pin level
  logic       strap_sync;    // Synchronised top address level
  pre_state_t st_reg;        // Reset entry state
  pre_state_t st_next;
  logic       test_reg;      // Latched test mode
  logic       test_next;
  logic       abort_reg;     // Abort pulse register
  logic       abort_next;
  pre_pins_t  out_reg;       // Registered pin drive
  pre_pins_t  out_next;

  // Pin group flattened so one loop covers every pin
  localparam int unsigned PIN_W = $bits(pre_pins_t);
  logic [PIN_W-1:0] drv_oe_vec;  // Core enables, one bit a pin
  logic [PIN_W-1:0] oe_vec;      // Enables after the reset gate
  logic [PIN_W-1:0] pu_vec;      // Pull-up requests per pin

  // State decode shared by the reset output and the checks
  function automatic logic st_is_reset(input pre_state_t s);
    return (s == PRE_ST_RESET);
  endfunction

  // Reset pin from the external source; parked at asserted so the
  // core cannot slip out of reset before the chain has filled
  pre_sync #(.RST_VAL(RST_PIN_RST)) u_rst_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (ext_reset_n),
    .sync_out (ext_rst_sync)
  );

  // Strap pin is external too
  pre_sync #(.RST_VAL(PIN_IDLE_RST)) u_strap_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .async_in (pins_in.addr19_test_strap),
    .sync_out (strap_sync)
  );

  // Next state; source keeps reset low through power-up and clock start
  // Strap and reset pin share one sync depth, so the strap level
  // seen at release is the level the pin had when reset rose
  // Lock and lower address pins are never looked at here [R6]
  always_comb begin
    st_next    = st_reg;
    test_next  = test_reg;
    abort_next = 1'b0;
    out_next   = pins_drv;
    case (st_reg)
      PRE_ST_RESET: begin
        if (ext_rst_sync) begin // [R1]
          st_next   = PRE_ST_RUN;
          // Only the top address pin counts, others ignored
          test_next = ~strap_sync; // [R6] [R7]
        end
      end
      PRE_ST_RUN: begin
        if (!ext_rst_sync) begin // [R1]
          st_next    = PRE_ST_RESET;
          abort_next = bus_cycle_active; // [R4]
        end
      end
      default: begin
        st_next = PRE_ST_RESET;
      end
    endcase
  end

  // State registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // Block reset: core held, pins parked high
      st_reg    <= PRE_ST_RESET;
      test_reg  <= TEST_MODE_RST;
      abort_reg <= 1'b0;
      out_reg   <= '1;
    end else begin
      st_reg    <= st_next;
      test_reg  <= test_next;
      abort_reg <= abort_next;
      out_reg   <= out_next;
    end
  end

  // Combinational reset entry so abort is not a cycle late
  logic in_reset;
  assign in_reset    = st_is_reset(st_reg) || !ext_rst_sync; // [R1]
  assign core_reset  = in_reset;
  // Bus logic must drop its cycle while this is high
  assign bus_abort   = in_reset & bus_cycle_active; // [R4]
  // Pin view as plain vectors for the per-pin loop
  assign drv_oe_vec  = pins_drv_oe;
  assign pins_oe     = oe_vec;
  assign pins_pullup = pu_vec;
  // Registered drive; only reaches the pad once the enable is back
  assign pins_out    = out_reg;
  // Latched strap decision, latched again at the release of every warm reset
  assign test_mode   = test_reg;

  // Per-pin float: every pin of the group behaves the same
  for (genvar g = 0; g < PIN_W; g++) begin : g_pin
    // Enable dropped at once, not at the next edge
    assign oe_vec[g] = in_reset ? 1'b0 : drv_oe_vec[g]; // [R5]
    // Weak pull-up only while held, so pads never float low
    assign pu_vec[g] = in_reset; // [R5]

    // While the synced reset pin is low every pin must be undriven and pulled up
    property p_pin_float;
      @(posedge ref_clk) disable iff (!rst_n)
        !ext_rst_sync |-> (!oe_vec[g] && pu_vec[g]);
    endproperty
    a_pin_float: assert property (p_pin_float) else $error("pin driven in reset"); // [R5]
  end

  // Reset keeps pins undriven
  property p_float;
    @(posedge ref_clk) disable iff (!rst_n)
      st_is_reset(st_reg) |-> (pins_oe == '0 && pins_pullup == '1);
  endproperty
  a_float: assert property (p_float) else $error("pins driven in reset"); // [R5]

  // Outside reset the core owns the enables and no pull-up acts
  property p_run_pins;
    @(posedge ref_clk) disable iff (!rst_n)
      !core_reset |-> (pins_oe == pins_drv_oe && pins_pullup == '0);
  endproperty
  a_run_pins: assert property (p_run_pins) else $error("pins wrong while running"); // [R5]

  // Drive register follows the core one cycle late
  property p_out;
    @(posedge ref_clk) disable iff (!rst_n)
      $past(rst_n) |-> (pins_out == $past(pins_drv));
  endproperty
  a_out: assert property (p_out) else $error("pin drive not registered"); // [R5]

  // Abort whenever the synced pin is low and a cycle runs
  property p_abort;
    @(posedge ref_clk) disable iff (!rst_n)
      (!ext_rst_sync && bus_cycle_active) |-> bus_abort;
  endproperty
  a_abort: assert property (p_abort) else $error("bus cycle not aborted"); // [R4]

  // No abort may reach the bus while the core runs
  property p_no_abort;
    @(posedge ref_clk) disable iff (!rst_n)
      !core_reset |-> !bus_abort;
  endproperty
  a_no_abort: assert property (p_no_abort) else $error("abort outside reset"); // [R4]

  // Entry record only set when the abort was shown on the bus
  property p_abort_entry;
    @(posedge ref_clk) disable iff (!rst_n)
      abort_reg |-> $past(bus_abort);
  endproperty
  a_abort_entry: assert property (p_abort_entry) else $error("abort record wrong"); // [R4]

  // Stays in reset while pin low
  property p_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      !ext_rst_sync |=> (st_reg == PRE_ST_RESET);
  endproperty
  a_hold: assert property (p_hold) else $error("left reset early"); // [R1]

  // Core reset rises in the cycle the synced pin falls
  property p_entry;
    @(posedge ref_clk) disable iff (!rst_n)
      $fell(ext_rst_sync) |-> core_reset;
  endproperty
  a_entry: assert property (p_entry) else $error("reset entry late"); // [R1]

  // Test mode follows strap at release
  property p_strap;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_is_reset(st_reg) && ext_rst_sync) |=> (test_mode == !$past(strap_sync));
  endproperty
  a_strap: assert property (p_strap) else $error("strap not latched"); // [R7]

  // A high strap selects nothing, whatever the other pins show
  property p_refuse;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_is_reset(st_reg) && ext_rst_sync && strap_sync) |=> !test_mode;
  endproperty
  a_refuse: assert property (p_refuse) else $error("test mode without strap"); // [R6]

  // Test mode untouched while the pin still holds reset
  property p_test_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_is_reset(st_reg) && !ext_rst_sync) |=> $stable(test_mode);
  endproperty
  a_test_hold: assert property (p_test_hold) else $error("test mode moved in reset"); // [R7]

  // Test mode stable while running
  property p_stable;
    @(posedge ref_clk) disable iff (!rst_n)
      (st_reg == PRE_ST_RUN && $past(st_reg) == PRE_ST_RUN) |-> $stable(test_mode);
  endproperty
  a_stable: assert property (p_stable) else $error("test mode changed"); // [R7]
endmodule

// File: test/pre_rst_src.sv
// Partner model: external reset source in front of the reset pin
`timescale 1ns/1ps
module pre_rst_src (
  input  wire logic ref_clk,
  input  wire logic hold,
  output logic      ext_reset_n
);
  int pwr_cnt; // Cycles since power came up, held once it reaches 6
  // One process owns both so each has a single driver
  initial begin
    pwr_cnt     = 0;
    ext_reset_n = 1'b0; // Low from power-up
    forever begin
      @(posedge ref_clk);
      // Power-up hold overrides requests so clocks can settle first
      ext_reset_n <= (pwr_cnt >= 6) && !hold;
      if (pwr_cnt < 6) begin
        pwr_cnt <= pwr_cnt + 1;
      end
    end
  end
endmodule

// File: test/tb_top.sv
// Bench for the reset entry block with reference model
`timescale 1ns/1ps
module tb_top;
  import pre_pkg::*;
  logic        ref_clk, rst_n, hold, ext_n, bca, cr, ab, tm, mtm;
  pre_pins_t   pin_i, drv, doe, p_out, p_oe, p_pu, pdrv;
  logic [15:0] rs;
  logic [4:0]  tbl [5] = '{5'h1F, 5'h17, 5'h18, 5'h0F, 5'h00}; // Strap cases
  int          err_total, n_checks;
  pre_rst_src src (.ref_clk(ref_clk), .hold(hold), .ext_reset_n(ext_n));
  pre_reset_entry uut (.ref_clk(ref_clk), .rst_n(rst_n), .ext_reset_n(ext_n),
    .pins_in(pin_i), .pins_drv(drv), .pins_drv_oe(doe), .bus_cycle_active(bca),
    .pins_out(p_out), .pins_oe(p_oe), .pins_pullup(p_pu), .core_reset(cr),
    .bus_abort(ab), .test_mode(tm));
  // Clock source
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Xorshift for the random bus traffic
  function automatic logic [15:0] xs(input logic [15:0] x);
    x ^= x << 7;
    x ^= x >> 9;
    x ^= x << 8;
    return x;
  endfunction
  // Compare one result
  task automatic chk(input logic [4:0] g, input logic [4:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One phase: set reset request and pins, settle, then random traffic
  task automatic phase(input logic h, input logic [4:0] pv);
    @(posedge ref_clk);
    hold <= h;
    pin_i <= pv; // Only strap low means test mode
    repeat (8) @(posedge ref_clk);
    if (!h) begin
      mtm = !pv[3]; // Test mode from the inverted strap level at release
    end
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      pdrv = drv;
      drv <= rs[4:0];
      doe <= rs[9:5];
      bca <= rs[10];
      @(negedge ref_clk);
      chk(cr, h);
      chk(ab, h & bca);
      chk(p_oe, h ? 5'h00 : doe);
      chk(p_pu, h ? 5'h1F : 5'h00);
      chk(tm, mtm);
      chk(p_out, pdrv);
      @(posedge ref_clk);
    end
  endtask
  // Main sequence
  initial begin
    {rst_n, hold, bca, mtm} = 4'h4;
    {pin_i, drv, doe} = '0;
    rs = 16'h0010;
    err_total = 0;
    n_checks = 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (tbl[k]) begin
      phase(1'b1, tbl[k]);
      phase(1'b0, tbl[k]);
    end
    report_and_stop;
  end
  // Watchdog against a hang
  initial begin
    #20000;
    err_total++;
    report_and_stop;
  end
endmodule
